// >>> design/vsc_defines.svh
// Constants for the serial command and telemetry block
// ****************************************************
// Function
// - Three wires: bus clock and command data from processor, return line from us.
// - Light and very light load indicators are active low power-state requests.
// - Light load indicator takes precedence over very light load indicator.
// - Light load asserted runs the shed phase count from the phase register.
// - Very light load in effect runs one phase in diode emulation.
// - Full configured phase count is restored in one step.
// - Loadline trim from packet bits 22 to 24, per rail, gated by enable and supply good.
// - Offset trim applied per rail only while enable and supply good.
// - Return line bits are timed by the processor bus clock edges.
// - Without supply good, no telemetry sampling and no return packets.
// - Voltage-only mode sends both rail voltages in every packet.
// - Voltage and current mode alternates main and bridge packets.
// - Voltage and current mode sends packets twice as often.
// - Reported values are moving averages of the samples.
// - Step done report only after a rail rises; never for down or equal.
// - Pending telemetry goes out before a pending step done report.
// - Step done report names only the rails that rose.
// - A newer voltage request replaces an unfinished step done report.
// - Telemetry start waits until an incoming command packet has ended.
// - A command arriving during telemetry is received; telemetry finishes.
// - Telemetry function field selects content; off stops sampling and sending.
// - Both bus clock rates are supported with their bus timing.
// - Without supply good, boot code is caught from bus clock and data levels.
// ****************************************************
`ifndef VSC_DEFINES_SVH
`define VSC_DEFINES_SVH
// Command packet layout, first bit received lands in the top bit
`define VSC_CMD_BITS 27
`define VSC_F_MAIN 26
`define VSC_F_BRIDGE 25
`define VSC_F_LL_HI 24
`define VSC_F_LL_LO 22
`define VSC_F_CODE_HI 21
`define VSC_F_CODE_LO 14
`define VSC_F_LIGHT_LOAD_INDICATOR 13
`define VSC_F_VERY_LIGHT_LOAD_INDICATOR 12
`define VSC_F_OFS_HI 11
`define VSC_F_OFS_LO 10
`define VSC_F_TFN_HI 9
`define VSC_F_TFN_LO 8
// Return packet: start bit, two type bits, sixteen payload bits
`define VSC_TX_BITS 19
`define VSC_TX_LAST 5'h12
`define VSC_TYPE_STEP 2'h0
`define VSC_TYPE_VOLT 2'h1
`define VSC_TYPE_MAIN 2'h2
`define VSC_TYPE_BRIDGE 2'h3
// Telemetry function codes
`define VSC_TFN_OFF 2'h0
`define VSC_TFN_VOLT 2'h1
`define VSC_TFN_VI 2'h2
// Timing
`define VSC_CLK_NS 25
`define VSC_TEL_PERIOD_NS 40000
`define VSC_TEL_CYCLES (`VSC_TEL_PERIOD_NS / `VSC_CLK_NS)
// Register offsets
`define VSC_REG_STATUS 4'h0
`define VSC_REG_MAIN_CODE 4'h1
`define VSC_REG_BRIDGE_CODE 4'h2
`define VSC_REG_PHASES 4'h3
// Reset values
`define VSC_RST_FULL 3'h4
`define VSC_RST_SHED 3'h2
`define VSC_RST_CODE 8'h00
`endif

// >>> design/vsc_pkg.sv
// Types for the serial command and telemetry block
package vsc_pkg;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} vsc_tx_e;
	typedef logic [7:0] vsc_code_t;
endpackage

// >>> design/vsc_serial_link.sv
// Serial command receiver, telemetry and step report sender
`timescale 1ns/100ps
`include "vsc_defines.svh"
module vsc_serial_link (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Link pins
	input wire logic serialBusClock,
	input wire logic serialCommandData,
	output logic telemetryReturnLine,
	output logic telemetryReturnOe,
	// Static pins
	input wire logic supplyGoodInput,
	input wire logic enableInput,
	// Samples and slew status from the regulator core
	input wire logic sampleStrobe,
	input wire logic [7:0] mainVoltSample,
	input wire logic [7:0] mainCurrSample,
	input wire logic [7:0] bridgeVoltSample,
	input wire logic [7:0] bridgeCurrSample,
	input wire logic mainAtTarget,
	input wire logic bridgeAtTarget,
	// Settings to the regulator core
	output logic [7:0] mainVoltCode,
	output logic [7:0] bridgeVoltCode,
	output logic [2:0] mainLoadlineTrim,
	output logic [2:0] bridgeLoadlineTrim,
	output logic [1:0] mainOffsetTrim,
	output logic [1:0] bridgeOffsetTrim,
	output logic [2:0] activePhases,
	output logic diodeEmulation,
	output logic [1:0] bootCode,
	// Register port
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData
);
	// ****************************************************
	// Input synchronisers
	// ****************************************************
	logic [2:0] sbcSync_reg;
	logic [2:0] scdSync_reg;
	logic [1:0] pgSync_reg;
	logic [1:0] enSync_reg;
	logic sbcRise, sbcFall, scdRise, scdFall, pgS, enS;

	// Two flops per pin, third flop only for edge finding
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sbcSync_reg <= 3'h7; // Idle high, no false edge
			scdSync_reg <= 3'h7;
			pgSync_reg <= 2'h0;
			enSync_reg <= 2'h0;
		end else begin
			sbcSync_reg <= {sbcSync_reg[1:0], serialBusClock};
			scdSync_reg <= {scdSync_reg[1:0], serialCommandData};
			pgSync_reg <= {pgSync_reg[0], supplyGoodInput};
			enSync_reg <= {enSync_reg[0], enableInput};
		end
	end

	// Edges seen by the system clock
	assign sbcRise = sbcSync_reg[1] & ~sbcSync_reg[2];
	assign sbcFall = ~sbcSync_reg[1] & sbcSync_reg[2];
	assign scdRise = scdSync_reg[1] & ~scdSync_reg[2];
	assign scdFall = ~scdSync_reg[1] & scdSync_reg[2];
	assign pgS = pgSync_reg[1];
	assign enS = enSync_reg[1];

	// ****************************************************
	// Boot code capture
	// ****************************************************
	logic [1:0] boot_reg;

	// Static clock and data levels caught while supply is not good
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			boot_reg <= 2'h0;
		else if (!pgS)
			boot_reg <= {sbcSync_reg[1], scdSync_reg[1]};
	end
	assign bootCode = boot_reg;

	// ****************************************************
	// Command receiver
	// ****************************************************
	logic rxBusy_reg;
	logic [4:0] rxCnt_reg;
	logic [26:0] rxShift_reg;
	logic startCond, stopCond, apply;

	// Data edges while the clock is high frame a packet
	assign startCond = scdFall & sbcSync_reg[1];
	assign stopCond = scdRise & sbcSync_reg[1];
	assign apply = stopCond & rxBusy_reg &
		(rxCnt_reg == 5'(`VSC_CMD_BITS));

	// Bits shifted in on bus clock rising edges
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rxBusy_reg <= 1'b0;
			rxCnt_reg <= 5'h0;
			rxShift_reg <= 27'h0;
		end else if (startCond) begin
			rxBusy_reg <= 1'b1;
			rxCnt_reg <= 5'h0;
		end else if (stopCond) begin
			rxBusy_reg <= 1'b0;
		end else if (rxBusy_reg && sbcRise) begin
			rxShift_reg <= {rxShift_reg[25:0], scdSync_reg[1]};
			if (rxCnt_reg != 5'h1F)
				rxCnt_reg <= rxCnt_reg + 5'h1;
		end
	end

	// ****************************************************
	// Applied settings
	// ****************************************************
	logic selMain, selBridge, gateOk;
	logic [7:0] newCode;
	logic [7:0] mainCode_reg, bridgeCode_reg;
	logic [2:0] mainLl_reg, bridgeLl_reg;
	logic [1:0] mainOfs_reg, bridgeOfs_reg;
	logic lightN_reg, veryLightN_reg;
	logic [1:0] tfn_reg;

	assign selMain = rxShift_reg[`VSC_F_MAIN];
	assign selBridge = rxShift_reg[`VSC_F_BRIDGE];
	assign newCode = rxShift_reg[`VSC_F_CODE_HI:`VSC_F_CODE_LO];
	assign gateOk = enS & pgS;

	// Fields take effect at the end of a whole packet
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mainCode_reg <= `VSC_RST_CODE;
			bridgeCode_reg <= `VSC_RST_CODE;
			lightN_reg <= 1'b1;
			veryLightN_reg <= 1'b1;
			tfn_reg <= `VSC_TFN_OFF;
		end else if (apply) begin
			if (selMain)
				mainCode_reg <= newCode;
			if (selBridge)
				bridgeCode_reg <= newCode;
			lightN_reg <= rxShift_reg[`VSC_F_LIGHT_LOAD_INDICATOR];
			veryLightN_reg <= rxShift_reg[`VSC_F_VERY_LIGHT_LOAD_INDICATOR];
			tfn_reg <= rxShift_reg[`VSC_F_TFN_HI:`VSC_F_TFN_LO];
		end
	end

	// Trims per rail, only with enable and supply good
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mainLl_reg <= 3'h0;
			bridgeLl_reg <= 3'h0;
			mainOfs_reg <= 2'h0;
			bridgeOfs_reg <= 2'h0;
		end else if (apply && gateOk) begin
			if (selMain) begin
				mainLl_reg <= rxShift_reg[`VSC_F_LL_HI:`VSC_F_LL_LO];
				mainOfs_reg <= rxShift_reg[`VSC_F_OFS_HI:`VSC_F_OFS_LO];
			end
			if (selBridge) begin
				bridgeLl_reg <= rxShift_reg[`VSC_F_LL_HI:`VSC_F_LL_LO];
				bridgeOfs_reg <= rxShift_reg[`VSC_F_OFS_HI:`VSC_F_OFS_LO];
			end
		end
	end
	assign mainVoltCode = mainCode_reg;
	assign bridgeVoltCode = bridgeCode_reg;
	assign mainLoadlineTrim = mainLl_reg;
	assign bridgeLoadlineTrim = bridgeLl_reg;
	assign mainOffsetTrim = mainOfs_reg;
	assign bridgeOffsetTrim = bridgeOfs_reg;

	// ****************************************************
	// Phase control and registers
	// ****************************************************
	logic [2:0] fullPh_reg, shedPh_reg, phases_reg;
	logic de_reg;

	// Phase counts written by software
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			fullPh_reg <= `VSC_RST_FULL;
			shedPh_reg <= `VSC_RST_SHED;
		end else if (regWr && regAddr == `VSC_REG_PHASES) begin
			fullPh_reg <= regWrData[2:0];
			shedPh_reg <= regWrData[6:4];
		end
	end

	// Very light load counts only under light load
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			phases_reg <= `VSC_RST_FULL;
			de_reg <= 1'b0;
		end else if (lightN_reg) begin
			phases_reg <= fullPh_reg;
			de_reg <= 1'b0;
		end else if (!veryLightN_reg) begin
			phases_reg <= 3'h1;
			de_reg <= 1'b1;
		end else begin
			phases_reg <= shedPh_reg;
			de_reg <= 1'b0;
		end
	end
	assign activePhases = phases_reg;
	assign diodeEmulation = de_reg;

	// Read data one cycle after the strobe, zero off the map
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			regRdData <= 8'h00;
		else if (regRd) begin
			unique case (regAddr)
				`VSC_REG_STATUS: regRdData <= {2'h0, tfn_reg, de_reg,
					phases_reg};
				`VSC_REG_MAIN_CODE: regRdData <= mainCode_reg;
				`VSC_REG_BRIDGE_CODE: regRdData <= bridgeCode_reg;
				`VSC_REG_PHASES: regRdData <= {1'b0, shedPh_reg, 1'b0,
					fullPh_reg};
				default: regRdData <= 8'h00;
			endcase
		end else
			regRdData <= 8'h00;
	end

	// ****************************************************
	// Moving averages
	// ****************************************************
	logic telOn;
	logic [7:0] avg [4];
	logic [7:0] smp [4];

	assign telOn = pgS & (tfn_reg != `VSC_TFN_OFF);
	assign smp[0] = mainVoltSample;
	assign smp[1] = mainCurrSample;
	assign smp[2] = bridgeVoltSample;
	assign smp[3] = bridgeCurrSample;

	// Quarter-weight running average per channel
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_avg
			logic [9:0] acc_reg;
			always_ff @(posedge clk_sys) begin
				if (sys_rst)
					acc_reg <= 10'h000;
				else if (sampleStrobe && telOn)
					acc_reg <= acc_reg - {2'h0, acc_reg[9:2]} +
						{2'h0, smp[gi]};
			end
			assign avg[gi] = acc_reg[9:2];
		end
	endgenerate

	// ****************************************************
	// Telemetry timer and step reports
	// ****************************************************
	logic [11:0] telTmr_reg;
	logic [11:0] telLimit;
	logic telPend_reg, telSel_reg, viMode;
	logic [1:0] riseWait_reg, stepMask_reg;
	logic stepPend_reg, stepDone;
	logic txStart, startTel, startStep;

	assign viMode = (tfn_reg == `VSC_TFN_VI);
	assign telLimit = viMode ? 12'(`VSC_TEL_CYCLES / 2 - 1) :
		12'(`VSC_TEL_CYCLES - 1);

	// Period timer raises a telemetry request
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			telTmr_reg <= 12'h000;
			telPend_reg <= 1'b0;
		end else if (!telOn) begin
			telTmr_reg <= 12'h000;
			telPend_reg <= 1'b0;
		end else if (telTmr_reg >= telLimit) begin
			telTmr_reg <= 12'h000;
			telPend_reg <= 1'b1;
		end else begin
			telTmr_reg <= telTmr_reg + 12'h001;
			if (startTel)
				telPend_reg <= 1'b0;
		end
	end

	// Rails waiting to finish a rise, replaced by each new request
	assign stepDone = (riseWait_reg != 2'h0) &&
		((~riseWait_reg | {mainAtTarget, bridgeAtTarget}) == 2'h3);
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			riseWait_reg <= 2'h0;
			stepPend_reg <= 1'b0;
			stepMask_reg <= 2'h0;
		end else begin
			if (apply && (selMain || selBridge))
				riseWait_reg <= {selMain && newCode > mainCode_reg,
					selBridge && newCode > bridgeCode_reg};
			else if (stepDone)
				riseWait_reg <= 2'h0;
			if (stepDone && !apply) begin
				stepPend_reg <= pgS;
				stepMask_reg <= riseWait_reg;
			end else if (startStep || !pgS)
				stepPend_reg <= 1'b0;
		end
	end

	// ****************************************************
	// Return line sender
	// ****************************************************
	vsc_pkg::vsc_tx_e txState_reg;
	logic [18:0] txShift_reg;
	logic [4:0] txCnt_reg;
	logic [15:0] telData;
	logic [1:0] telType;

	// Start on a falling clock edge, never during a command
	assign txStart = (txState_reg == vsc_pkg::TX_IDLE) && sbcFall &&
		pgS && !rxBusy_reg && !startCond;
	assign startTel = txStart && telPend_reg;
	assign startStep = txStart && !telPend_reg && stepPend_reg;

	// Payload choice by telemetry mode and alternation
	always_comb begin
		if (!viMode) begin
			telType = `VSC_TYPE_VOLT;
			telData = {avg[0], avg[2]};
		end else if (!telSel_reg) begin
			telType = `VSC_TYPE_MAIN;
			telData = {avg[0], avg[1]};
		end else begin
			telType = `VSC_TYPE_BRIDGE;
			telData = {avg[2], avg[3]};
		end
	end

	// Alternation between main and bridge packets
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !viMode)
			telSel_reg <= 1'b0;
		else if (startTel)
			telSel_reg <= ~telSel_reg;
	end

	// Shifts on falling edges; receiver runs on regardless
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			txState_reg <= vsc_pkg::TX_IDLE;
			txShift_reg <= 19'h0;
			txCnt_reg <= 5'h0;
		end else begin
			unique case (txState_reg)
				vsc_pkg::TX_IDLE: begin
					txCnt_reg <= 5'h0;
					if (startTel) begin
						txShift_reg <= {1'b1, telType, telData};
						txState_reg <= vsc_pkg::TX_SEND;
					end else if (startStep) begin
						txShift_reg <= {1'b1, `VSC_TYPE_STEP, 14'h0,
							stepMask_reg};
						txState_reg <= vsc_pkg::TX_SEND;
					end
				end
				vsc_pkg::TX_SEND: begin
					if (!pgS) begin
						txState_reg <= vsc_pkg::TX_IDLE;
						txShift_reg <= 19'h0;
					end else if (sbcFall) begin
						txShift_reg <= {txShift_reg[17:0], 1'b0};
						txCnt_reg <= txCnt_reg + 5'h1;
						if (txCnt_reg == `VSC_TX_LAST)
							txState_reg <= vsc_pkg::TX_IDLE;
					end
				end
			endcase
		end
	end
	assign telemetryReturnLine = (txState_reg == vsc_pkg::TX_SEND) &
		txShift_reg[18];
	assign telemetryReturnOe = 1'b1;

	// ****************************************************
	// Assertions
	// ****************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_pg_stop;
		!pgS |=> txState_reg == vsc_pkg::TX_IDLE && !stepPend_reg;
	endproperty
	a_pg_stop: assert property (p_pg_stop)
		else $error("return line active without supply good");

	property p_rx_hold;
		rxBusy_reg |-> !txStart;
	endproperty
	a_rx_hold: assert property (p_rx_hold)
		else $error("telemetry started during a command");

	property p_precedence;
		lightN_reg ##1 lightN_reg |-> phases_reg == $past(fullPh_reg) && !de_reg;
	endproperty
	a_precedence: assert property (p_precedence)
		else $error("very light load acted without light load");

	property p_single;
		!lightN_reg && !veryLightN_reg |=> de_reg && phases_reg == 3'h1;
	endproperty
	a_single: assert property (p_single)
		else $error("very light load not single phase");

	property p_shed;
		!lightN_reg && veryLightN_reg |=> phases_reg == $past(shedPh_reg);
	endproperty
	a_shed: assert property (p_shed)
		else $error("light load phase count wrong");

	property p_ll_gate;
		$changed(mainLl_reg) |-> $past(apply && gateOk);
	endproperty
	a_ll_gate: assert property (p_ll_gate)
		else $error("loadline trim changed while gated");

	property p_ofs_gate;
		$changed(bridgeOfs_reg) |-> $past(apply && gateOk);
	endproperty
	a_ofs_gate: assert property (p_ofs_gate)
		else $error("offset trim changed while gated");

	property p_prio;
		txStart && telPend_reg |=> txShift_reg[17:16] != `VSC_TYPE_STEP;
	endproperty
	a_prio: assert property (p_prio)
		else $error("step report sent before telemetry");

	property p_fall_edge;
		txState_reg == vsc_pkg::TX_SEND && pgS && !sbcFall |=>
			$stable(txShift_reg);
	endproperty
	a_fall_edge: assert property (p_fall_edge)
		else $error("return line moved off a falling edge");

	property p_apply_end;
		$changed(mainCode_reg) |-> $past(apply);
	endproperty
	a_apply_end: assert property (p_apply_end)
		else $error("voltage code changed before packet end");

	c_tel: cover property (startTel);
	c_step: cover property (startStep);
	c_apply: cover property (apply);
	c_rx_in_tx: cover property (startCond &&
		txState_reg == vsc_pkg::TX_SEND);
endmodule

// >>> testbench/vsc_proc_model.sv
// Processor side model of the serial command link
`timescale 1ns/100ps
module vsc_proc_model (
	// Link pins
	output logic serialBusClock,
	output logic serialCommandData,
	input wire logic telemetryReturnLine
);
	localparam int HALF = 100;
	logic [17:0] rxPkt[$];
	realtime rxTime[$];
	logic [17:0] sh;
	int cnt = -1;
	// Clock parked high and data high between frames
	initial begin
		serialBusClock = 1'b1;
		serialCommandData = 1'b1;
	end
	// Static levels for boot code capture
	task automatic set_levels(input logic c, input logic d);
		serialBusClock <= c;
		serialCommandData <= d;
	endtask
	// Start, n bits top first, stop; last bit sent must be 0
	task automatic send_cmd(input logic [26:0] pkt, input int n);
		#(HALF) serialCommandData <= 1'b0;
		for (int i = 26; i > 26 - n; i--) begin
			#(HALF) serialBusClock <= 1'b0;
			#(HALF / 2) serialCommandData <= pkt[i];
			#(HALF / 2) serialBusClock <= 1'b1;
		end
		#(HALF / 2) serialCommandData <= 1'b1;
		#(HALF);
	endtask
	// Idle clocking so the return line can talk
	task automatic run_clock(input int n);
		repeat (n) begin
			#(HALF) serialBusClock <= 1'b0;
			#(HALF) serialBusClock <= 1'b1;
		end
	endtask
	// Return packets sampled on rising bus clock edges
	always @(posedge serialBusClock) begin
		if (cnt < 0) begin
			if (telemetryReturnLine === 1'b1) begin
				cnt = 0;
				rxTime.push_back($realtime);
			end
		end else begin
			sh = {sh[16:0], telemetryReturnLine};
			cnt++;
			if (cnt == 18) begin
				rxPkt.push_back(sh);
				cnt = -1;
			end
		end
	end
endmodule

// >>> testbench/vsc_serial_link_tb.sv
// Self-checking bench for the serial command and telemetry block
`timescale 1ns/100ps
module vsc_serial_link_tb;
	logic clk_sys = 1'b0;
	logic sys_rst, supplyGoodInput, enableInput, sampleStrobe;
	logic [7:0] mainVoltSample, mainCurrSample, bridgeVoltSample;
	logic [7:0] bridgeCurrSample;
	logic mainAtTarget, bridgeAtTarget, regWr, regRd;
	logic [3:0] regAddr;
	logic [7:0] regWrData, regRdData, mainVoltCode, bridgeVoltCode;
	logic [2:0] mainLoadlineTrim, bridgeLoadlineTrim, activePhases;
	logic [1:0] mainOffsetTrim, bridgeOffsetTrim, bootCode, p;
	logic serialBusClock, serialCommandData;
	logic telemetryReturnLine, telemetryReturnOe, diodeEmulation;
	logic [1:0] psiTab [4] = '{2'b01, 2'b00, 2'b11, 2'b10};
	int mismatches = 0;
	int checks = 0;
	// ****************************************************
	// Instances
	// ****************************************************
	vsc_serial_link dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.serialBusClock(serialBusClock),
		.serialCommandData(serialCommandData),
		.telemetryReturnLine(telemetryReturnLine),
		.telemetryReturnOe(telemetryReturnOe),
		.supplyGoodInput(supplyGoodInput), .enableInput(enableInput),
		.sampleStrobe(sampleStrobe), .mainVoltSample(mainVoltSample),
		.mainCurrSample(mainCurrSample), .bridgeVoltSample(bridgeVoltSample),
		.bridgeCurrSample(bridgeCurrSample), .mainAtTarget(mainAtTarget),
		.bridgeAtTarget(bridgeAtTarget), .mainVoltCode(mainVoltCode),
		.bridgeVoltCode(bridgeVoltCode), .mainLoadlineTrim(mainLoadlineTrim),
		.bridgeLoadlineTrim(bridgeLoadlineTrim),
		.mainOffsetTrim(mainOffsetTrim), .bridgeOffsetTrim(bridgeOffsetTrim),
		.activePhases(activePhases), .diodeEmulation(diodeEmulation),
		.bootCode(bootCode), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData));
	vsc_proc_model proc_u (.serialBusClock(serialBusClock),
		.serialCommandData(serialCommandData),
		.telemetryReturnLine(telemetryReturnLine));
	// System clock, 25 ns period
	always #12.5 clk_sys = ~clk_sys;
	// ****************************************************
	// Tasks
	// ****************************************************
	task automatic check(input logic [17:0] got, exp, input string msg);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg,
				got, exp);
		end
	endtask
	task automatic complete_run();
		if (mismatches == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		@(negedge clk_sys);
		check(regRdData, exp, "register read");
	endtask
	task automatic cmd(input logic m, b, input logic [2:0] ll,
		input logic [7:0] code, input logic p0, p1,
		input logic [1:0] ofs, telemetry_function_select, input int n);
		proc_u.send_cmd({m, b, ll, code, p0, p1, ofs, telemetry_function_select, 8'h00}, n);
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic feed(input logic [7:0] mv, mi, bv, bi, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			sampleStrobe <= 1'b1;
			mainVoltSample <= mv;
			mainCurrSample <= mi;
			bridgeVoltSample <= bv;
			bridgeCurrSample <= bi;
			@(posedge clk_sys);
			sampleStrobe <= 1'b0;
		end
	endtask
	// Rails reach target, then count the return packets
	task automatic step_done(input int n, input logic [17:0] exp);
		proc_u.rxPkt.delete();
		@(posedge clk_sys);
		mainAtTarget <= 1'b1;
		bridgeAtTarget <= 1'b1;
		repeat (4) @(posedge clk_sys);
		proc_u.run_clock(30);
		check(18'(proc_u.rxPkt.size()), 18'(n), "step report count");
		if (n > 0 && proc_u.rxPkt.size() > 0) begin
			check(proc_u.rxPkt[0], exp, "step report");
		end
		@(posedge clk_sys);
		mainAtTarget <= 1'b0;
		bridgeAtTarget <= 1'b0;
	endtask
	// Expect silence on the return line
	task automatic quiet(input int n);
		proc_u.run_clock(25);
		proc_u.rxPkt.delete();
		proc_u.run_clock(n);
		check(18'(proc_u.rxPkt.size()), 18'h0, "packets while silent");
	endtask
	// Two periodic telemetry packets: content and spacing
	task automatic tel_pair(input realtime per, input logic [17:0] ea, eb);
		realtime dt;
		proc_u.rxPkt.delete();
		proc_u.rxTime.delete();
		proc_u.run_clock(int'(per * 3.5 / 200.0));
		check(18'(proc_u.rxPkt.size() >= 3), 18'h1, "telemetry count");
		if (proc_u.rxPkt.size() >= 3) begin
			dt = proc_u.rxTime[2] - proc_u.rxTime[1];
			check(18'(dt > per - 400.0 && dt < per + 400.0), 18'h1, "interval");
			if (proc_u.rxPkt[1][17:16] === eb[17:16]) begin
				check(proc_u.rxPkt[1], eb, "telemetry packet");
				check(proc_u.rxPkt[2], ea, "telemetry packet");
			end else begin
				check(proc_u.rxPkt[1], ea, "telemetry packet");
				check(proc_u.rxPkt[2], eb, "telemetry packet");
			end
		end
	endtask
	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		sys_rst = 1'b1;
		supplyGoodInput = 1'b1;
		enableInput = 1'b1;
		{sampleStrobe, mainAtTarget, bridgeAtTarget, regWr, regRd} = 5'h00;
		{mainVoltSample, mainCurrSample} = 16'h0000;
		{bridgeVoltSample, bridgeCurrSample} = 16'h0000;
		regAddr = 4'h0;
		regWrData = 8'h00;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		check({telemetryReturnOe, telemetryReturnLine}, 2'h2, "line idle");
		rd_chk(4'h0, 8'h04);
		rd_chk(4'h1, 8'h00);
		rd_chk(4'h3, 8'h24);
		rd_chk(4'hF, 8'h00);
		wr(4'h0, 8'hFF);
		wr(4'h9, 8'hFF);
		rd_chk(4'h0, 8'h04);
		wr(4'h3, 8'h53);
		rd_chk(4'h3, 8'h53);
		check(activePhases, 3'h3, "full phase count");
		// Power-state table: full 3, shed 5
		for (int i = 0; i < 4; i++) begin
			p = psiTab[i];
			cmd(0, 0, 3'h0, 8'h00, p[1], p[0], 2'h0, 2'h0, 27);
			check({diodeEmulation, activePhases}, p[1] ? 4'h3 :
				(p[0] ? 4'h5 : 4'h9), "power state");
		end
		// Trims, codes and step reports
		cmd(1, 1, 3'h5, 8'h40, 1, 1, 2'h2, 2'h0, 27);
		check({mainVoltCode, bridgeVoltCode}, 16'h4040, "codes");
		check({mainLoadlineTrim, bridgeLoadlineTrim}, 6'h2D, "trims");
		check({mainOffsetTrim, bridgeOffsetTrim}, 4'hA, "offsets");
		step_done(1, 18'h00003);
		cmd(1, 1, 3'h1, 8'h20, 1, 1, 2'h1, 2'h0, 26);
		check(mainVoltCode, 8'h40, "short packet");
		enableInput <= 1'b0;
		cmd(1, 1, 3'h3, 8'h40, 1, 1, 2'h1, 2'h0, 27);
		check({mainLoadlineTrim, mainOffsetTrim}, 5'h16, "disabled");
		step_done(0, 18'h0);
		enableInput <= 1'b1;
		cmd(0, 1, 3'h6, 8'h30, 1, 1, 2'h3, 2'h0, 27);
		check({mainLoadlineTrim, bridgeLoadlineTrim}, 6'h2E, "rail");
		check({mainOffsetTrim, bridgeOffsetTrim}, 4'hB, "rail");
		step_done(0, 18'h0);
		cmd(1, 1, 3'h6, 8'h40, 1, 1, 2'h3, 2'h0, 27);
		step_done(1, 18'h00001);
		cmd(1, 0, 3'h6, 8'h50, 1, 1, 2'h3, 2'h0, 27);
		cmd(1, 0, 3'h6, 8'h60, 1, 1, 2'h3, 2'h0, 27);
		check(mainVoltCode, 8'h60, "newer code");
		step_done(1, 18'h00002);
		// Command received while a step report goes out
		cmd(1, 0, 3'h6, 8'h70, 1, 1, 2'h3, 2'h0, 27);
		@(posedge clk_sys);
		mainAtTarget <= 1'b1;
		repeat (4) @(posedge clk_sys);
		proc_u.rxPkt.delete();
		proc_u.run_clock(2);
		cmd(0, 1, 3'h6, 8'h20, 1, 1, 2'h3, 2'h0, 27);
		mainAtTarget <= 1'b0;
		check(18'(proc_u.rxPkt.size()), 18'h1, "overlap count");
		check(proc_u.rxPkt[0], 18'h00002, "overlap report");
		check(bridgeVoltCode, 8'h20, "overlap command");
		// Telemetry, voltage only then voltage and current
		cmd(0, 0, 3'h0, 8'h00, 1, 1, 2'h0, 2'h1, 27);
		feed(8'h40, 8'h21, 8'h80, 8'h11, 60);
		feed(8'h00, 8'h21, 8'h00, 8'h11, 1);
		tel_pair(40000.0, 18'h13060, 18'h13060);
		cmd(0, 0, 3'h0, 8'h00, 1, 1, 2'h0, 2'h2, 27);
		tel_pair(20000.0, 18'h23021, 18'h36011);
		cmd(0, 0, 3'h0, 8'h00, 1, 1, 2'h0, 2'h0, 27);
		quiet(250);
		cmd(0, 0, 3'h0, 8'h00, 1, 1, 2'h0, 2'h1, 27);
		supplyGoodInput <= 1'b0;
		quiet(250);
		proc_u.set_levels(1'b1, 1'b0);
		repeat (8) @(posedge clk_sys);
		check(bootCode, 2'h2, "boot code");
		proc_u.set_levels(1'b0, 1'b1);
		repeat (8) @(posedge clk_sys);
		check(bootCode, 2'h1, "boot code");
		proc_u.set_levels(1'b1, 1'b1);
		complete_run();
	end
	// Watchdog against a hung sequence
	initial begin
		#2000000;
		mismatches++;
		complete_run();
	end
endmodule
